// File: uart1_cfg.svh
// Offsets, field positions, reset values and tick counts of the serial port.
// Assumes byte addresses on a 32-bit Avalon-MM bus, one register per word.
`ifndef UART1_CFG_SVH
`define UART1_CFG_SVH
// ==========================================
// Register byte offsets
`define OFF_SCTL 8'hc0
`define OFF_AMASK 8'hc4
`define OFF_SADDR 8'hc8
`define OFF_PCTL 8'hcc
`define OFF_DATA 8'hd0
`define OFF_ISTAT 8'hd4
`define OFF_IMASK 8'hd8
// ==========================================
// Control register fields
`define B_SM0 7
`define B_SM1 6
`define B_SM2 5
`define B_REN 4
`define B_TB8 3
`define B_RB8 2
`define B_TI 1
`define B_RI 0
// Power control fields
`define B_SMOD 7
`define B_FESEL 6
// Interrupt status fields
`define B_IST_TX 0
`define B_IST_RX 1
`define B_IST_FE 2
// ==========================================
// Reset values
`define RST_SCTL 8'h00
`define RST_AMASK 8'h00
`define RST_SADDR 8'h00
`define RST_PCTL 8'h00
`define RST_IREG 3'h0
// ==========================================
// Tick counts (last value of each counter, and the mid-bit sample point)
`define M0_SLOW_LAST 4'h5
`define M0_FAST_LAST 4'h1
`define M2_SLOW_LAST 4'h3
`define M2_FAST_LAST 4'h1
`define T1_SLOW_LAST 4'h1
`define T1_FAST_LAST 4'h0
`define M0_BIT_LAST 4'h1
`define ASYNC_BIT_LAST 4'hf
`define MID_SAMPLE 4'h7
`endif

// File: uart1_pkg.sv
// Types shared by the serial port modules.
// Assumes uart1_cfg.svh provides the numeric constants.
package uart1_pkg;
	// ==========================================
	// Types
	typedef logic [7:0] byte_t;
	typedef logic [1:0] mode_t;
	typedef enum logic {TX_IDLE, TX_RUN} tx_state_e;
	typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_ASYNC} rx_state_e;
endpackage : uart1_pkg

// File: uart1_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes an idle-high serial line.
`timescale 1ns/1ps
module uart1_sync (
	input wire logic mclk, // System clock.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic pin, // Raw pin level.
	output logic level // Filtered level.
);
	logic s1_r, s2_r, s3_r, level_r, level_nxt;
	// ==========================================
	// The output moves only once stages two and three agree.
	always_comb begin
		level_nxt = (s2_r == s3_r) ? s3_r : level_r;
	end
	// Registers of the synchroniser chain.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			level_r <= 1'b1;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			level_r <= level_nxt;
		end
	end
	assign level = level_r;
endmodule : uart1_sync

// File: uart1_baud.sv
// Baud tick generator: half-bit ticks in mode 0, sixteen ticks a bit otherwise.
// Assumes the timer overflow is a one-cycle pulse on mclk.
`timescale 1ns/1ps
`include "uart1_cfg.svh"
module uart1_baud (
	input wire logic mclk, // System clock.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire uart1_pkg::mode_t mode, // Operating mode.
	input wire logic fast, // Mode 0 divide by 4 select.
	input wire logic smod, // Rate doubling select.
	input wire logic t1_ovf, // Timer overflow pulse.
	output logic tick // One-cycle tick.
);
	import uart1_pkg::*;
	logic [3:0] cnt_r, cnt_nxt, last;
	logic tick_r, tick_nxt, inc;
	// ==========================================
	// Select divisor and count source.
	always_comb begin
		last = smod ? `M2_FAST_LAST : `M2_SLOW_LAST;
		inc = 1'b1;
		if (mode == 2'b00) begin
			last = fast ? `M0_FAST_LAST : `M0_SLOW_LAST;
		end else if (mode[0]) begin
			last = smod ? `T1_FAST_LAST : `T1_SLOW_LAST;
			inc = t1_ovf;
		end
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (inc) begin
			if (cnt_r >= last) begin
				cnt_nxt = 4'h0;
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 4'h1;
			end
		end
	end
	// Divider registers.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 4'h0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end
	assign tick = tick_r;
endmodule : uart1_baud

// File: serial_port_one_uart.sv
// Second serial port: four modes, ninth bit, address filter, framing error.
// Assumes an Avalon-MM master on mclk and a timer overflow pulse on mclk.
//
// What this block does
// - Compare address only where mask bit set.
// - All-zero mask accepts every address byte.
// - Control bit 7 is mode or error.
// - Invalid stop sets error flag until cleared.
// - Mode bits pick shift, 10-bit, 11-bit frames.
// - Multiprocessor modes 2/3 drop ninth-bit-zero bytes.
// - Multiprocessor mode 1 needs valid stop bit.
// - Mode 0 clock divides by 12 or 4.
// - Receive starts only while receive enable set; a frame under way completes.
// - Software ninth bit sent unchanged.
// - Received ninth bit holds bit9 or stop.
// - Transmit flag set per mode, software clears.
// - Variable rate comes from timer overflow only.
`timescale 1ns/1ps
`include "uart1_cfg.svh"
module serial_port_one_uart (
	input wire logic mclk, // System clock, 40 MHz.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic [7:0] address, // Avalon byte address.
	input wire logic read, // Avalon read.
	input wire logic write, // Avalon write.
	input wire logic [31:0] writedata, // Avalon write data.
	input wire logic [3:0] byteenable, // Avalon byte enables.
	output logic [31:0] readdata, // Avalon read data.
	output logic waitrequest, // Avalon wait request.
	input wire logic t1_overflow, // Timer overflow pulse.
	input wire logic rxd_in, // Data pin level.
	output logic rxd_out, // Data pin drive value in mode 0.
	output logic rxd_oe_n, // Data pin enable, low drives.
	output logic txd, // Serial out or mode 0 clock.
	output logic irq // Interrupt, high active.
);
	import uart1_pkg::*;
	// Address decode shared by read and write paths.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit
	// Address filter: mask bits of zero are ignored.
	function automatic logic addr_match(input byte_t d, input byte_t sa, input byte_t m);
		addr_match = (((d ^ sa) & m) == 8'h00);
	endfunction : addr_match

	// ==========================================
	// Declarations
	logic wait_r, wait_nxt, do_wr;
	logic [31:0] rdata_r, rdata_nxt;
	byte_t rmux;
	logic sm0_r, sm1_r, sm2_r, ren_r, tb8_r, rb8_r, ti_r, ri_r, fe_r;
	logic sm0_nxt, sm1_nxt, sm2_nxt, ren_nxt, tb8_nxt, rb8_nxt, ti_nxt, ri_nxt, fe_nxt;
	byte_t amask_r, amask_nxt, saddr_r, saddr_nxt, rxbuf_r, rxbuf_nxt;
	logic smod_r, smod_nxt, fesel_r, fesel_nxt;
	logic [2:0] istat_r, istat_nxt, imask_r, imask_nxt;
	logic irq_r, irq_nxt;
	mode_t mode;
	logic tick, rx_lvl, rx_prev_r;
	tx_state_e tx_st_r, tx_st_nxt;
	logic [10:0] tx_sh_r, tx_sh_nxt;
	logic [3:0] tx_idx_r, tx_idx_nxt, tx_sub_r, tx_sub_nxt, tx_nb, bit_last;
	logic tx_evt;
	rx_state_e rx_st_r, rx_st_nxt;
	logic [8:0] rx_sh_r, rx_sh_nxt;
	logic [3:0] rx_idx_r, rx_idx_nxt, rx_sub_r, rx_sub_nxt;
	logic rx_evt, fe_evt, rx_load, rx_rb8;
	logic txd_r, txd_nxt, rdo_r, rdo_nxt, oen_r, oen_nxt;

	assign mode = {sm0_r, sm1_r};
	assign bit_last = (mode == 2'b00) ? `M0_BIT_LAST : `ASYNC_BIT_LAST;
	assign tx_nb = (mode == 2'b00) ? 4'd8 : ((mode == 2'b01) ? 4'd10 : 4'd11);

	// ==========================================
	// Submodules
	uart1_sync u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.pin(rxd_in),
		.level(rx_lvl)
	);
	uart1_baud u_baud (
		.mclk(mclk),
		.rstn(rstn),
		.mode(mode),
		.fast(sm2_r),
		.smod(smod_r),
		.t1_ovf(t1_overflow),
		.tick(tick)
	);

	// ==========================================
	// Bus slave: one wait cycle, then the access completes.
	always_comb begin
		rmux = 8'h00;
		if (hit(address, `OFF_SCTL)) begin
			rmux = {fesel_r ? fe_r : sm0_r, sm1_r, sm2_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
		end else if (hit(address, `OFF_AMASK)) begin
			rmux = amask_r;
		end else if (hit(address, `OFF_SADDR)) begin
			rmux = saddr_r;
		end else if (hit(address, `OFF_PCTL)) begin
			rmux = {smod_r, fesel_r, 6'h00};
		end else if (hit(address, `OFF_DATA)) begin
			rmux = rxbuf_r;
		end else if (hit(address, `OFF_ISTAT)) begin
			rmux = {5'h00, istat_r};
		end else if (hit(address, `OFF_IMASK)) begin
			rmux = {5'h00, imask_r};
		end
		wait_nxt = 1'b1;
		rdata_nxt = rdata_r;
		if ((read || write) && wait_r) begin
			wait_nxt = 1'b0;
			rdata_nxt = {24'h000000, rmux};
		end
	end
	assign do_wr = write && !wait_r && byteenable[0];
	// Bus registers.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h00000000;
		end else begin
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ==========================================
	// Control and status registers; hardware sets win over software clears.
	always_comb begin
		sm0_nxt = sm0_r;
		sm1_nxt = sm1_r;
		sm2_nxt = sm2_r;
		ren_nxt = ren_r;
		tb8_nxt = tb8_r;
		rb8_nxt = rb8_r;
		ti_nxt = ti_r;
		ri_nxt = ri_r;
		fe_nxt = fe_r;
		amask_nxt = amask_r;
		saddr_nxt = saddr_r;
		smod_nxt = smod_r;
		fesel_nxt = fesel_r;
		rxbuf_nxt = rxbuf_r;
		istat_nxt = istat_r;
		imask_nxt = imask_r;
		if (do_wr && hit(address, `OFF_SCTL)) begin
			if (fesel_r) begin
				fe_nxt = writedata[`B_SM0];
			end else begin
				sm0_nxt = writedata[`B_SM0];
			end
			sm1_nxt = writedata[`B_SM1];
			sm2_nxt = writedata[`B_SM2];
			ren_nxt = writedata[`B_REN];
			tb8_nxt = writedata[`B_TB8];
			rb8_nxt = writedata[`B_RB8];
			ti_nxt = writedata[`B_TI];
			ri_nxt = writedata[`B_RI];
		end
		if (do_wr && hit(address, `OFF_AMASK)) begin
			amask_nxt = writedata[7:0];
		end
		if (do_wr && hit(address, `OFF_SADDR)) begin
			saddr_nxt = writedata[7:0];
		end
		if (do_wr && hit(address, `OFF_PCTL)) begin
			smod_nxt = writedata[`B_SMOD];
			fesel_nxt = writedata[`B_FESEL];
		end
		if (do_wr && hit(address, `OFF_IMASK)) begin
			imask_nxt = writedata[2:0];
		end
		if (do_wr && hit(address, `OFF_ISTAT)) begin
			istat_nxt = istat_r & ~writedata[2:0];
		end
		if (tx_evt) begin
			ti_nxt = 1'b1;
			istat_nxt[`B_IST_TX] = 1'b1;
		end
		if (rx_load) begin
			rxbuf_nxt = rx_sh_r[7:0];
			rb8_nxt = rx_rb8;
		end
		if (rx_evt) begin
			ri_nxt = 1'b1;
			istat_nxt[`B_IST_RX] = 1'b1;
		end
		if (fe_evt) begin
			fe_nxt = 1'b1;
			istat_nxt[`B_IST_FE] = 1'b1;
		end
		irq_nxt = |(istat_nxt & imask_nxt);
	end
	// Control register storage.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{sm0_r, sm1_r, sm2_r, ren_r, tb8_r, rb8_r, ti_r, ri_r} <= `RST_SCTL;
			fe_r <= 1'b0;
			amask_r <= `RST_AMASK;
			saddr_r <= `RST_SADDR;
			{smod_r, fesel_r} <= 2'(`RST_PCTL >> 6);
			rxbuf_r <= 8'h00;
			istat_r <= `RST_IREG;
			imask_r <= `RST_IREG;
			irq_r <= 1'b0;
		end else begin
			{sm0_r, sm1_r, sm2_r, ren_r, tb8_r, rb8_r, ti_r, ri_r} <=
				{sm0_nxt, sm1_nxt, sm2_nxt, ren_nxt, tb8_nxt, rb8_nxt, ti_nxt, ri_nxt};
			fe_r <= fe_nxt;
			amask_r <= amask_nxt;
			saddr_r <= saddr_nxt;
			{smod_r, fesel_r} <= {smod_nxt, fesel_nxt};
			rxbuf_r <= rxbuf_nxt;
			istat_r <= istat_nxt;
			imask_r <= imask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ==========================================
	// Transmitter: a data write starts a frame, LSB first.
	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_sh_nxt = tx_sh_r;
		tx_idx_nxt = tx_idx_r;
		tx_sub_nxt = tx_sub_r;
		tx_evt = 1'b0;
		case (tx_st_r)
			TX_IDLE: begin
				if (do_wr && hit(address, `OFF_DATA)) begin
					if (mode == 2'b00) begin
						tx_sh_nxt = {3'h7, writedata[7:0]};
					end else if (mode == 2'b01) begin
						tx_sh_nxt = {2'h3, writedata[7:0], 1'b0};
					end else begin
						tx_sh_nxt = {1'b1, tb8_r, writedata[7:0], 1'b0};
					end
					// Mode 0 holds its clock high until the divider ticks, so no half is cut short.
					tx_idx_nxt = (mode == 2'b00) ? 4'hf : 4'h0;
					tx_sub_nxt = 4'h0;
					tx_st_nxt = TX_RUN;
				end
			end
			TX_RUN: begin
				if (tick) begin
					if (tx_idx_r == 4'hf) begin
						tx_idx_nxt = 4'h0;
					end else if (tx_sub_r == bit_last) begin
						tx_sub_nxt = 4'h0;
						tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
						tx_idx_nxt = tx_idx_r + 4'h1;
						// Mode 0 flags after bit 8; others at stop bit start.
						tx_evt = (tx_idx_r == tx_nb - ((mode == 2'b00) ? 4'd1 : 4'd2));
						if (tx_idx_r == tx_nb - 4'd1) begin
							tx_st_nxt = TX_IDLE;
						end
					end else begin
						tx_sub_nxt = tx_sub_r + 4'h1;
					end
				end
			end
			default: tx_st_nxt = TX_IDLE;
		endcase
	end
	// Transmitter registers.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tx_st_r <= TX_IDLE;
			tx_sh_r <= 11'h7ff;
			tx_idx_r <= 4'h0;
			tx_sub_r <= 4'h0;
		end else begin
			tx_st_r <= tx_st_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_idx_r <= tx_idx_nxt;
			tx_sub_r <= tx_sub_nxt;
		end
	end

	// ==========================================
	// Receiver: mode 0 shifts on its own clock, other modes oversample 16x.
	always_comb begin
		rx_st_nxt = rx_st_r;
		rx_sh_nxt = rx_sh_r;
		rx_idx_nxt = rx_idx_r;
		rx_sub_nxt = rx_sub_r;
		rx_evt = 1'b0;
		rx_load = 1'b0;
		fe_evt = 1'b0;
		rx_rb8 = rb8_r;
		case (rx_st_r)
			RX_IDLE: begin
				rx_idx_nxt = 4'h0;
				rx_sub_nxt = 4'h0;
				if (ren_r && tx_st_r == TX_IDLE && mode == 2'b00 && !ri_r) begin
					rx_st_nxt = RX_SYNC;
				end else if (ren_r && mode != 2'b00 && rx_prev_r && !rx_lvl) begin
					rx_st_nxt = RX_ASYNC;
				end
			end
			RX_SYNC: begin
				if (tick) begin
					rx_sub_nxt = rx_sub_r ^ 4'h1;
					if (rx_sub_r == 4'h0) begin
						rx_sh_nxt[rx_idx_r[2:0]] = rx_lvl;
					end else begin
						rx_idx_nxt = rx_idx_r + 4'h1;
						if (rx_idx_r == 4'd7) begin
							rx_load = 1'b1;
							rx_evt = 1'b1;
							rx_st_nxt = RX_IDLE;
						end
					end
				end
			end
			RX_ASYNC: begin
				if (tick) begin
					rx_sub_nxt = (rx_sub_r == `ASYNC_BIT_LAST) ? 4'h0 : rx_sub_r + 4'h1;
					if (rx_sub_r == `MID_SAMPLE) begin
						rx_idx_nxt = rx_idx_r + 4'h1;
						if (rx_idx_r == 4'h0) begin
							if (rx_lvl) begin
								rx_st_nxt = RX_IDLE; // False start.
							end
						end else if (rx_idx_r != tx_nb - 4'd1) begin
							rx_sh_nxt[rx_idx_r - 4'd1] = rx_lvl;
						end else begin
							rx_st_nxt = RX_IDLE;
							fe_evt = !rx_lvl;
							if (mode == 2'b01) begin
								rx_rb8 = rx_lvl;
								rx_load = !ri_r && (!sm2_r || rx_lvl);
							end else begin
								rx_rb8 = rx_sh_r[8];
								rx_load = !ri_r && (!sm2_r || (rx_sh_r[8] &&
									addr_match(rx_sh_r[7:0], saddr_r, amask_r)));
							end
							rx_evt = rx_load;
						end
					end
				end
			end
			default: rx_st_nxt = RX_IDLE;
		endcase
	end
	// Receiver registers.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_st_r <= RX_IDLE;
			rx_sh_r <= 9'h000;
			rx_idx_r <= 4'h0;
			rx_sub_r <= 4'h0;
			rx_prev_r <= 1'b1;
		end else begin
			rx_st_r <= rx_st_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_idx_r <= rx_idx_nxt;
			rx_sub_r <= rx_sub_nxt;
			rx_prev_r <= rx_lvl;
		end
	end

	// ==========================================
	// Pin drive: mode 0 puts the shift clock on txd and, while sending, data on the data pin.
	always_comb begin
		txd_nxt = 1'b1;
		rdo_nxt = 1'b1;
		oen_nxt = 1'b1;
		if (tx_st_nxt == TX_RUN) begin
			if (mode == 2'b00) begin
				txd_nxt = tx_sub_nxt[0] | (tx_idx_nxt == 4'hf);
				rdo_nxt = tx_sh_nxt[0];
				oen_nxt = 1'b0;
			end else begin
				txd_nxt = tx_sh_nxt[0];
			end
		end else if (rx_st_nxt == RX_SYNC) begin
			txd_nxt = rx_sub_nxt[0];
		end
	end
	// Pin registers.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			txd_r <= 1'b1;
			rdo_r <= 1'b1;
			oen_r <= 1'b1;
		end else begin
			txd_r <= txd_nxt;
			rdo_r <= rdo_nxt;
			oen_r <= oen_nxt;
		end
	end

	assign readdata = rdata_r;
	assign waitrequest = wait_r;
	assign irq = irq_r;
	assign txd = txd_r;
	assign rxd_out = rdo_r;
	assign rxd_oe_n = oen_r;
endmodule : serial_port_one_uart

// File: serial_port_one_uart_monitor.sv
// Checks on the serial port bus answers, reset state and mode 0 shift clock.
// Assumes a bind to serial_port_one_uart, seeing only its ports.
`timescale 1ns/1ps
`include "uart1_cfg.svh"
module serial_port_one_uart_monitor (
	input wire logic mclk, // Clock.
	input wire logic rstn, // Reset, active low.
	input wire logic [7:0] address, // Bus address.
	input wire logic read, // Bus read.
	input wire logic write, // Bus write.
	input wire logic [31:0] writedata, // Bus write data.
	input wire logic [3:0] byteenable, // Bus byte enables.
	input wire logic [31:0] readdata, // Bus read data.
	input wire logic waitrequest, // Bus wait.
	input wire logic rxd_out, // Data pin value.
	input wire logic rxd_oe_n, // Data pin enable, low drives.
	input wire logic txd, // Serial out or shift clock.
	input wire logic irq // Interrupt.
);
	// ==========================================
	// Bus handshake and reset state
	// One clock domain, so clock and reset are named once.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	property p_ack;
		(read || write) && waitrequest |=> !waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("request not answered");
	property p_once;
		!waitrequest |=> waitrequest;
	endproperty
	a_once: assert property (p_once) else $error("answer held too long");
	property p_idle;
		!read && !write |=> waitrequest;
	endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_upper;
		!waitrequest |-> readdata[31:8] == 24'h0;
	endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_hold;
		waitrequest |-> $stable(readdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved between accesses");
	property p_rst;
		$rose(rstn) |-> waitrequest && !irq && txd && rxd_oe_n;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	// ==========================================
	// Interrupt and shift clock
	property p_mask;
		write && !waitrequest && byteenable[0] && address == `OFF_IMASK
			&& writedata[2:0] == 3'h0 |-> ##2 !irq;
	endproperty
	a_mask: assert property (p_mask) else $error("masked interrupt still high");
	property p_m0clk;
		$fell(txd) && !rxd_oe_n |-> !txd[*2] ##1 (txd or (!txd[*4] ##1 txd));
	endproperty
	a_m0clk: assert property (p_m0clk) else $error("shift clock low half wrong");
	property p_m0data;
		$rose(txd) && !rxd_oe_n |-> $stable(rxd_out);
	endproperty
	a_m0data: assert property (p_m0data) else $error("shift data moved at clock");
	c_wr: cover property (write && !waitrequest);
	c_irq: cover property ($rose(irq));
	c_m0: cover property ($fell(txd) && !rxd_oe_n);
endmodule : serial_port_one_uart_monitor

bind serial_port_one_uart serial_port_one_uart_monitor i_serial_port_one_uart_monitor (
	.mclk(mclk), .rstn(rstn), .address(address), .read(read), .write(write),
	.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd), .irq(irq)
);

// File: uart1_line_model.sv
// Peer serial device facing the port's data and clock pins.
// Assumes an idle-high line and one bit every BIT cycles of mclk.
`timescale 1ns/1ps
module uart1_line_model #(
	parameter int BIT = 32 // Cycles per bit.
) (
	input wire logic mclk, // Clock.
	input wire logic txd, // Serial in or shift clock.
	input wire logic rxd_out, // Shifted data in mode 0.
	input wire logic rxd_oe_n, // Data pin enable, low drives.
	output logic line_rxd // Line level sent to the device.
);
	// The line rests high between frames.
	initial line_rxd = 1'b1;
	// Sends n bits, first bit first, then returns the line to idle.
	task automatic send(input logic [10:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			line_rxd <= f[i];
			repeat (BIT) @(posedge mclk);
		end
		line_rxd <= 1'b1;
	endtask : send
	// Samples an eleven-bit frame in the middle of each bit.
	task automatic grab(output logic [10:0] f);
		int n;
		n = 0;
		while (txd !== 1'b0 && n < 4000) begin
			@(posedge mclk);
			n++;
		end
		repeat (BIT / 2) @(posedge mclk);
		for (int i = 0; i < 11; i++) begin
			f[i] = txd;
			repeat (BIT) @(posedge mclk);
		end
	endtask : grab
	// Takes eight mode 0 bits at the rising shift clock.
	task automatic shift_in(output logic [7:0] d);
		logic prev;
		int i;
		prev = 1'b1;
		i = 0;
		while (i < 8) begin
			@(posedge mclk);
			if (!rxd_oe_n && txd && !prev) begin
				d[i] = rxd_out;
				i++;
			end
			prev = txd;
		end
	endtask : shift_in
endmodule : uart1_line_model

// File: serial_port_one_uart_tb.sv
// Self-checking bench: registers, frames in all modes, flags and interrupt.
// Assumes the line model as peer and a timer overflow every second cycle.
`timescale 1ns/1ps
`include "uart1_cfg.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module serial_port_one_uart_tb;
	localparam int BIT = 32; // Sixteen overflows a bit, one every second cycle.
	logic mclk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0, t1_overflow = 1'b0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest, rxd_out, rxd_oe_n, txd, irq, line_rxd, pin;
	logic [10:0] fr;
	logic [7:0] v;
	logic [7:0] offs [6] = '{`OFF_SCTL, `OFF_AMASK, `OFF_SADDR, `OFF_PCTL, `OFF_ISTAT, `OFF_IMASK};
	int fail_count = 0, samples_checked = 0, cyc = 0;
	// The data pin carries the device's value only while it drives.
	assign pin = rxd_oe_n ? line_rxd : rxd_out;
	serial_port_one_uart i_serial_port_one_uart (
		.mclk(mclk), .rstn(rstn), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'h1), .readdata(readdata),
		.waitrequest(waitrequest), .t1_overflow(t1_overflow), .rxd_in(pin),
		.rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd), .irq(irq)
	);
	uart1_line_model #(.BIT(BIT)) i_uart1_line_model (
		.mclk(mclk), .txd(txd), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .line_rxd(line_rxd)
	);
	// Clock, timer overflow pulses and a cycle ceiling against hangs.
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) t1_overflow <= ~t1_overflow;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	// One bus access, held until waitrequest is seen low.
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge mclk);
		address <= a;
		writedata <= {24'h0, d};
		write <= w;
		read <= !w;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		q = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(a, 1'b1, d, q);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(a, 1'b0, 8'h00, q);
		`CHK(q, e);
	endtask : rchk
	// Sends one frame, checks the receive flag, then clears it.
	task automatic rx(input logic b9, input logic [7:0] d, input logic st, input logic ri,
		input int n);
		logic [7:0] q;
		i_uart1_line_model.send({st, b9, d, 1'b0}, n);
		repeat (40) @(posedge mclk);
		bus(`OFF_SCTL, 1'b0, 8'h00, q);
		`CHK(q[0], ri);
		wr(`OFF_SCTL, q & 8'hfe);
	endtask : rx
	// Main sequence.
	initial begin
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		foreach (offs[i]) rchk(offs[i], 8'h00);
		wr(8'h10, 8'hff);
		rchk(8'h10, 8'h00);
		wr(`OFF_AMASK, 8'h5a);
		rchk(`OFF_AMASK, 8'h5a);
		wr(`OFF_PCTL, 8'h80);
		wr(`OFF_IMASK, 8'h07);
		for (int b = 0; b < 2; b++) begin
			wr(`OFF_SCTL, {4'h8, b[0], 3'h0});
			fork
				i_uart1_line_model.grab(fr);
				wr(`OFF_DATA, 8'ha5);
			join
			`CHK(fr, {1'b1, b[0], 8'ha5, 1'b0});
			rchk(`OFF_SCTL, {4'h8, b[0], 3'h2});
		end
		rchk(`OFF_ISTAT, 8'h01);
		`CHK(irq, 1'b1);
		wr(`OFF_IMASK, 8'h00);
		repeat (2) @(posedge mclk);
		`CHK(irq, 1'b0);
		wr(`OFF_IMASK, 8'h07);
		wr(`OFF_SCTL, 8'h80);
		wr(`OFF_ISTAT, 8'h07);
		repeat (2) @(posedge mclk);
		`CHK(irq, 1'b0);
		for (int s = 0; s < 2; s++) begin
			wr(`OFF_SCTL, {2'h0, s[0], 5'h00});
			fork
				i_uart1_line_model.shift_in(v);
				wr(`OFF_DATA, 8'h3c);
			join
			repeat (8) @(posedge mclk);
			`CHK(v, 8'h3c);
			rchk(`OFF_SCTL, {2'h0, s[0], 5'h02});
		end
		wr(`OFF_SADDR, 8'h42);
		wr(`OFF_AMASK, 8'hf0);
		wr(`OFF_SCTL, 8'hf0);
		rx(1'b0, 8'h42, 1'b1, 1'b0, 11);
		rx(1'b1, 8'h52, 1'b1, 1'b0, 11);
		rx(1'b1, 8'h4f, 1'b1, 1'b1, 11);
		rchk(`OFF_DATA, 8'h4f);
		rchk(`OFF_SCTL, 8'hf4);
		wr(`OFF_AMASK, 8'h00);
		rx(1'b1, 8'h99, 1'b1, 1'b1, 11);
		rchk(`OFF_DATA, 8'h99);
		wr(`OFF_SCTL, 8'he0);
		rx(1'b1, 8'h42, 1'b1, 1'b0, 11);
		wr(`OFF_SCTL, 8'h70);
		wr(`OFF_PCTL, 8'hc0);
		rx(1'b0, 8'h11, 1'b1, 1'b0, 10);
		rchk(`OFF_SCTL, 8'hf0);
		rx(1'b1, 8'h22, 1'b1, 1'b1, 10);
		rchk(`OFF_SCTL, 8'hf4);
		wr(`OFF_SCTL, 8'h70);
		rchk(`OFF_SCTL, 8'h70);
		fork
			i_uart1_line_model.grab(fr);
			wr(`OFF_DATA, 8'h5c);
		join
		`CHK(fr, {2'h3, 8'h5c, 1'b0});
		rchk(`OFF_SCTL, 8'h72);
		wrap_up();
	end
endmodule : serial_port_one_uart_tb
